/* File: bench/prc_ref_config_assertions.sv */
// Checker for the reference configuration register bank.
// Assumes it is bound to prc_ref_config and sees only its ports.
module prc_ref_config_assertions
    import prc_pkg::*;
#(
    parameter int SRC_COUNT = 64,
    parameter int STATUS_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic cfg_load_status,
    input wire logic [SRC_COUNT-1:0] status_sources,
    input wire logic diff_ref_mode,
    input wire logic ref_input_b_en,
    input wire logic crystal_maintaining_amp_en,
    input wire logic ref_doubler_en,
    input wire logic status_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic done = psel && penable && pready && ce;
    wire logic wr = done && pwrite && pstrb[0];
    logic ovr_reg, frz_reg, held_reg;
    logic [7:0] rb_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Shadow of override and freeze bits, and the latest frozen readback seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ovr_reg, frz_reg, held_reg, rb_reg} <= '0;
        end else begin
            if (wr && paddr == 12'h074) {ovr_reg, frz_reg} <= {pwdata[7], pwdata[4]};
            if (done && !pwrite && paddr == 12'h07c && frz_reg) begin
                held_reg <= 1'h1;
                rb_reg <= prdata[7:0];
            end
            if (!frz_reg) held_reg <= 1'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_DIFF: assert property (wr && paddr == 12'h070 |=> diff_ref_mode == $past(pwdata[0]))
        else $error("diff mode differs from write");
    AST_REFB: assert property (wr && paddr == 12'h070 |=> ref_input_b_en == $past(pwdata[2]))
        else $error("second input enable differs from write");
    AST_XTAL: assert property (wr && paddr == 12'h074 |=> crystal_maintaining_amp_en == $past(pwdata[6]))
        else $error("amplifier enable differs from write");
    AST_DBL: assert property (wr && paddr == 12'h074 |=> ref_doubler_en == $past(pwdata[5]))
        else $error("doubler enable differs from write");
    AST_OVR: assert property (ce && ovr_reg && !wr |=> status_pin == $past(cfg_load_status))
        else $error("status pin not showing load status");
    AST_PRIO: assert property (ce && ovr_reg && !wr && !cfg_load_status && |status_sources |=> !status_pin)
        else $error("selection beat the override");
    AST_FRZ: assert property (done && !pwrite && paddr == 12'h07c && frz_reg && held_reg |-> prdata[7:0] == rb_reg)
        else $error("readback changed while frozen");
    COV_OVR: cover property (ce && ovr_reg && cfg_load_status);
    COV_FRZ: cover property (done && frz_reg && held_reg);
    COV_DIFF: cover property (wr && paddr == 12'h070 && pwdata[0]);
endmodule
bind prc_ref_config prc_ref_config_assertions #(.SRC_COUNT(SRC_COUNT), .STATUS_W(STATUS_W)) u_chk (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .cfg_load_status, .status_sources, .diff_ref_mode, .ref_input_b_en, .crystal_maintaining_amp_en,
    .ref_doubler_en, .status_pin);

/* File: bench/test_pll_reference_input_config.sv */
// Testbench for the reference configuration register bank.
// Assumes the checker file is compiled alongside; APB master is this bench.
module test_pll_reference_input_config;
    import prc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cfg_load_status = 0, ce = 1;
    logic [3:0] pstrb = 4'hf;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] pll_status = '0;
    logic [63:0] status_sources = '0;
    logic pready, pslverr, err, diff_ref_mode, ref_input_a_en, ref_input_b_en;
    logic crystal_maintaining_amp_en, ref_doubler_en, status_pin;
    int n_mismatch = 0, num_checks = 0, cycles = 0;
    prc_ref_config DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .pll_status, .cfg_load_status, .status_sources, .diff_ref_mode,
        .ref_input_a_en, .ref_input_b_en, .crystal_maintaining_amp_en, .ref_doubler_en, .status_pin);
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(negedge pclk);
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_mode();
        rdchk("mode_rst", 12'h070, 32'h0);
        rdchk("path_rst", 12'h074, 32'h0);
        apb(1'h1, 12'h070, 32'h1);
        chk("mode_outs", 32'h1, {ref_input_b_en, ref_input_a_en, diff_ref_mode});
        apb(1'h1, 12'h070, 32'hfe);
        chk("mode_outs", 32'h6, {ref_input_b_en, ref_input_a_en, diff_ref_mode});
        rdchk("mode_rd", 12'h070, 32'he6);
        apb(1'h1, 12'h074, 32'h40);
        chk("path_outs", 32'h2, {crystal_maintaining_amp_en, ref_doubler_en});
        apb(1'h1, 12'h074, 32'h20);
        chk("path_outs", 32'h1, {crystal_maintaining_amp_en, ref_doubler_en});
    endtask
    task automatic t_status();
        @(posedge pclk);
        status_sources <= 64'h8;
        apb(1'h1, 12'h05c, 32'hc);
        @(negedge pclk);
        chk("pin_sel", 32'h1, status_pin);
        apb(1'h1, 12'h074, 32'h80);
        @(negedge pclk);
        chk("pin_ovr", 32'h0, status_pin);
        @(posedge pclk);
        cfg_load_status <= 1'h1;
        @(posedge pclk);
        @(negedge pclk);
        chk("pin_ovr", 32'h1, status_pin);
    endtask
    task automatic t_freeze();
        @(posedge pclk);
        pll_status <= 8'h5a;
        rdchk("readback", 12'h07c, 32'h5a);
        apb(1'h1, 12'h074, 32'h10);
        @(posedge pclk);
        pll_status <= 8'ha5;
        rdchk("readback", 12'h07c, 32'h5a);
        @(posedge pclk);
        pll_status <= 8'h3c;
        rdchk("readback", 12'h07c, 32'h5a);
        apb(1'h1, 12'h074, 32'h0);
        rdchk("readback", 12'h07c, 32'h3c);
        apb(1'h0, 12'h100, 32'h0);
        chk("slverr", 32'h1, err);
        chk("slverr_data", 32'h0, rd);
    endtask
    // Write strobe gating and clock enable freeze
    task automatic t_gate();
        @(posedge pclk);
        pstrb <= 4'h0;
        apb(1'h1, 12'h074, 32'h60);
        chk("strobe_gate", 32'h0, {crystal_maintaining_amp_en, ref_doubler_en});
        @(posedge pclk);
        pstrb <= 4'hf;
        ce <= 1'h0;
        status_sources <= 64'h0;
        repeat (3) @(negedge pclk);
        chk("ce_hold", 32'h1, status_pin);
        @(posedge pclk);
        ce <= 1'h1;
        @(posedge pclk);
        @(negedge pclk);
        chk("ce_resume", 32'h0, status_pin);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        t_mode();
        t_status();
        t_freeze();
        t_gate();
        wrap_up();
    end
endmodule

/* File: verilog/prc_pkg.sv */
// Package for the PLL reference input configuration block.
// Assumes an APB slave that has 32-bit data and holds one register in each aligned word.
package prc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [7:0] PRC_IDX_STATUS_PIN_SEL = 8'h17;
    localparam logic [7:0] PRC_IDX_REF_MODE_CTL = 8'h1c;
    localparam logic [7:0] PRC_IDX_REF_PATH_CTL = 8'h1d;
    localparam logic [7:0] PRC_IDX_PLL_READBACK = 8'h1f;
    localparam int PRC_ADDR_W = 12;
    localparam int PRC_ADDR_SHIFT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the reference input mode control register
    localparam int PRC_BIT_DIFF_MODE = 0;
    localparam int PRC_BIT_REF_A_EN = 1;
    localparam int PRC_BIT_REF_B_EN = 2;
    localparam int PRC_RSV_LO = 3;
    localparam int PRC_RSV_HI = 4;

    // Field positions of the reference path and status control register
    localparam int PRC_BIT_CFG_LOAD_OVR = 7;
    localparam int PRC_BIT_XTAL_AMP_EN = 6;
    localparam int PRC_BIT_DOUBLER_EN = 5;
    localparam int PRC_BIT_READBACK_FREEZE = 4;

    // Status pin selection field
    localparam int PRC_SEL_LO = 2;
    localparam int PRC_SEL_HI = 7;
    localparam int PRC_SEL_W = PRC_SEL_HI - PRC_SEL_LO + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and the reserved-bit mask
    localparam logic [7:0] PRC_RST_REF_MODE_CTL = 8'h00;
    localparam logic [7:0] PRC_RST_REF_PATH_CTL = 8'h00;
    localparam logic [7:0] PRC_RST_STATUS_PIN_SEL = 8'h00;
    localparam logic [7:0] PRC_RST_READBACK = 8'h00;
    localparam logic [7:0] PRC_RSV_MASK = 8'he7;

endpackage

/* File: verilog/prc_ref_config.sv */
// PLL reference input configuration register bank with APB access.
// Assumes an APB master on pclk; pll_status and status sources are synchronous to pclk.
// Register layout; the byte address is four times the word index
// Every register is eight bits wide, carried in pwdata[7:0] and prdata[7:0]
// Status pin select, index 0x17:
//   bits 7:2 - monitor signal routed to the status pin
//   bits 1:0 - stored and read back, no effect here
// Reference input mode control, index 0x1c:
//   bit 0    - differential reference mode
//   bit 1    - first single-ended input power
//   bit 2    - second single-ended input power
//   bits 4:3 - reserved, dropped on write and read as zero
//   bits 7:5 - stored and read back, no effect here
// Reference path and status control, index 0x1d:
//   bit 7    - load status override of the status pin
//   bit 6    - crystal maintaining amplifier enable
//   bit 5    - reference doubler enable
//   bit 4    - readback freeze
//   bits 3:0 - stored and read back, no effect here
// PLL status readback, index 0x1f:
//   read only; writes complete without effect
//   follows pll_status on every enabled cycle unless frozen
//
// Bus timing, one wait state on every transfer
//   setup cycle   - psel high, penable low
//   first access  - answer and error flag prepared at its closing edge
//   second access - pready high; the transfer completes at its closing edge
//   next cycle    - control outputs show a written value
// A read returns the readback value held in the first access cycle.
// Unmapped, misaligned or out-of-range addresses answer with pslverr and read zero.
// Writes need pstrb[0]; a write without it completes with no effect and no error.
// Bits 31:8 of the read data are always zero.
//
// Hazards and limits
//   ce low freezes every flop, including a transfer in flight and the status pin
//   the single-ended enables are not cleared in differential mode;
//   software must keep them clear before setting the mode bit
//   the status pin lags its source by one clock
//   a selection index beyond the source count drives the pin low
//   the override is clear after reset, so the selection drives the pin
//   the readback freezes on the edge at which the freeze bit is written
module prc_ref_config
    import prc_pkg::*;
#(
    // Number of monitor signals selectable onto the status pin
    parameter int SRC_COUNT = 64,
    // Width of the PLL status word
    parameter int STATUS_W = 8
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status and monitor inputs
    input wire logic [STATUS_W-1:0] pll_status,
    input wire logic cfg_load_status,
    input wire logic [SRC_COUNT-1:0] status_sources,
    // Reference path controls and status pin
    output logic diff_ref_mode,
    output logic ref_input_a_en,
    output logic ref_input_b_en,
    output logic crystal_maintaining_amp_en,
    output logic ref_doubler_en,
    output logic status_pin
);

    // State of the bank apart from the status pin flop, which sits in prc_status_pin
    typedef struct packed {
        // Control registers
        logic [7:0] mode_ctl;
        logic [7:0] path_ctl;
        logic [7:0] pin_sel;
        // PLL status readback
        logic [STATUS_W-1:0] readback;
        // Bus answer
        logic ready;
        logic slverr;
        logic [7:0] rdata;
    } prc_state_type;

    // State and decode
    prc_state_type state_reg;
    prc_state_type state_next;
    logic access;
    logic [7:0] word_index;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode: word index of the byte address
    function automatic logic [7:0] prc_index(input logic [PRC_ADDR_W-1:0] addr);
        logic [PRC_ADDR_W-1:0] idx;
        idx = addr >> PRC_ADDR_SHIFT;
        return idx[7:0];
    endfunction

    // Mapped: aligned, no address bit above the index, and one of the four words
    function automatic logic prc_mapped(input logic [PRC_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = prc_index(addr);
        return (addr[PRC_ADDR_SHIFT-1:0] == '0) && ((addr >> (PRC_ADDR_SHIFT + $bits(idx))) == '0) &&
               (idx == PRC_IDX_STATUS_PIN_SEL || idx == PRC_IDX_REF_MODE_CTL ||
                idx == PRC_IDX_REF_PATH_CTL || idx == PRC_IDX_PLL_READBACK);
    endfunction

    // Read value of one word; anything unmapped reads zero
    function automatic logic [7:0] prc_read_word(input logic [7:0] idx, input prc_state_type st);
        logic [7:0] value;
        case (idx)
            PRC_IDX_STATUS_PIN_SEL: value = st.pin_sel;
            PRC_IDX_REF_MODE_CTL: value = st.mode_ctl;
            PRC_IDX_REF_PATH_CTL: value = st.path_ctl;
            PRC_IDX_PLL_READBACK: value = 8'(st.readback);
            default: value = 8'h00;
        endcase
        return value;
    endfunction

    // Access phase of a transfer and the word it names
    assign access = psel && penable;
    assign word_index = prc_index(paddr);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave, register writes and readback refresh
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            // Readback follows the PLL unless frozen
            if (!state_reg.path_ctl[PRC_BIT_READBACK_FREEZE]) begin
                state_next.readback = pll_status;
            end
            if (access && !state_reg.ready) begin
                // First access cycle: prepare the answer, complete on the next edge
                state_next.ready = 1'b1;
                state_next.slverr = !prc_mapped(paddr);
                state_next.rdata = prc_read_word(word_index, state_reg);
                // Writes and unmapped reads answer zero
                if (pwrite || !prc_mapped(paddr)) begin
                    state_next.rdata = 8'h00;
                end
            end else if (access && state_reg.ready) begin
                // Completion edge: the write takes effect here only
                state_next.ready = 1'b0;
                state_next.slverr = 1'b0;
                if (pwrite && pstrb[0] && prc_mapped(paddr)) begin
                    // Readback word takes no write
                    case (word_index)
                        PRC_IDX_STATUS_PIN_SEL: state_next.pin_sel = pwdata[7:0];
                        PRC_IDX_REF_MODE_CTL: state_next.mode_ctl = pwdata[7:0] & PRC_RSV_MASK;
                        PRC_IDX_REF_PATH_CTL: state_next.path_ctl = pwdata[7:0];
                        default: state_next.mode_ctl = state_reg.mode_ctl;
                    endcase
                end
            end else begin
                // Idle or setup cycle: no answer pending
                state_next.ready = 1'b0;
                state_next.slverr = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Registers take their reset values, no answer pending
            state_reg.mode_ctl <= PRC_RST_REF_MODE_CTL;
            state_reg.path_ctl <= PRC_RST_REF_PATH_CTL;
            state_reg.pin_sel <= PRC_RST_STATUS_PIN_SEL;
            state_reg.readback <= STATUS_W'(PRC_RST_READBACK);
            state_reg.ready <= 1'b0;
            state_reg.slverr <= 1'b0;
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status pin selection with override
    prc_status_pin #(
        .SRC_COUNT(SRC_COUNT)
    ) u_status_pin (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .cfg_load_override(state_reg.path_ctl[PRC_BIT_CFG_LOAD_OVR]),
        .pin_select(state_reg.pin_sel[PRC_SEL_HI:PRC_SEL_LO]),
        .cfg_load_status(cfg_load_status),
        .status_sources(status_sources),
        .status_pin(status_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs straight from the registers
    assign prdata = {24'h000000, state_reg.rdata};
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;

    // Reference path controls
    assign diff_ref_mode = state_reg.mode_ctl[PRC_BIT_DIFF_MODE];
    assign ref_input_a_en = state_reg.mode_ctl[PRC_BIT_REF_A_EN];
    assign ref_input_b_en = state_reg.mode_ctl[PRC_BIT_REF_B_EN];
    assign crystal_maintaining_amp_en = state_reg.path_ctl[PRC_BIT_XTAL_AMP_EN];
    assign ref_doubler_en = state_reg.path_ctl[PRC_BIT_DOUBLER_EN];

endmodule

/* File: verilog/prc_status_pin.sv */
// Status pin selector: picks one monitor signal, or the configuration-load status when overridden.
// Assumes the monitor signals and the load status are synchronous to pclk.
module prc_status_pin
    import prc_pkg::*;
#(
    parameter int SRC_COUNT = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic cfg_load_override,
    input wire logic [PRC_SEL_W-1:0] pin_select,
    input wire logic cfg_load_status,
    input wire logic [SRC_COUNT-1:0] status_sources,
    output logic status_pin
);

    typedef struct packed {
        logic pin;
    } prc_pin_state_type;

    prc_pin_state_type state_reg;
    prc_pin_state_type state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Override beats the selection field
    always_comb begin
        state_next = state_reg;
        if (ce) begin
            if (cfg_load_override) begin
                state_next.pin = cfg_load_status;
            end else if (int'(pin_select) < SRC_COUNT) begin
                state_next.pin = status_sources[pin_select];
            end else begin
                state_next.pin = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign status_pin = state_reg.pin;

endmodule
